//--- include/pgm_pkg.sv
/*
 pgm_pkg: offsets, field positions, reset values, timing counts and carrier
 structs for the power-good mask and discharge control register bank.
 Assumes a single 25 MHz core clock; factory defaults arrive as parameters.
*/
`default_nettype none
package pgm_pkg;
	localparam logic [7:0] OFS_PG_MASK = 8'hac;
	localparam logic [7:0] OFS_TERM_DISCH = 8'had;
	localparam logic [7:0] OFS_ADJ_RAIL = 8'hae;

	localparam int unsigned POS_PG1_IN3 = 7;
	localparam int unsigned POS_PG1_IN6 = 6;
	localparam int unsigned POS_PG4_IN3 = 5;
	localparam int unsigned POS_PG4_IN6 = 4;
	localparam int unsigned POS_PG2_IN3 = 3;
	localparam int unsigned POS_PG2_IN6 = 2;
	localparam int unsigned POS_PG3_IN3 = 1;
	localparam int unsigned POS_PG3_IN6 = 0;

	localparam int unsigned POS_TERM_DISCH = 4;
	localparam int unsigned POS_ADJ_DISCH_HI = 7;
	localparam int unsigned POS_ADJ_DISCH_LO = 6;
	localparam int unsigned POS_SDWN_CFG = 5;
	localparam int unsigned POS_VCODE_HI = 4;
	localparam int unsigned POS_VCODE_LO = 1;
	localparam int unsigned POS_RAIL_EN = 0;

	// neutral defaults; real parts load a factory option
	localparam logic [7:0] RST_PG_MASK = 8'hff;
	localparam logic [7:0] RST_TERM_DISCH = 8'h00;
	localparam logic [7:0] RST_ADJ_RAIL = 8'h00;

	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned SDWN_MS_1 = 1;
	localparam int unsigned SDWN_MS_5 = 5;
	localparam int unsigned SDWN_MS_10 = 10;
	localparam int unsigned SDWN_MS_100 = 100;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam logic [31:0] SDWN_CYC_1 = 32'(SDWN_MS_1 * CYC_PER_MS);
	localparam logic [31:0] SDWN_CYC_5 = 32'(SDWN_MS_5 * CYC_PER_MS);
	localparam logic [31:0] SDWN_CYC_10 = 32'(SDWN_MS_10 * CYC_PER_MS);
	localparam logic [31:0] SDWN_CYC_100 = 32'(SDWN_MS_100 * CYC_PER_MS);

	typedef enum logic [1:0] {
		DISCH_NONE,
		DISCH_100,
		DISCH_200,
		DISCH_500
	} pgm_disch_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pgm_req_s;

	typedef struct packed {
		pgm_disch_e disch_sel;
		logic sdwn_cfg;
		logic [3:0] vcode;
		logic en;
	} pgm_rail_s;
endpackage
`default_nettype wire

//--- sim/pgm_regs_assertions.sv
/*
 pgm_regs_assertions: port-level checks for pgm_regs.
 Assumes default parameters, so the adjustable regulator is the selected rail.
*/
`timescale 1ns/1ps
`default_nettype none
module pgm_regs_assertions (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic EMERGENCY_SHUTDOWN,
	input wire logic TERMINATION_DISCHARGE_SEL,
	input wire logic [1:0] ADJ_REG_DISCHARGE_SEL,
	input wire logic [3:0] ADJ_REG_VOLTAGE_CODE,
	input wire logic ADJ_REG_ONE_ON
);
	logic [7:0] rail_r;
	logic wr_ad;
	logic wr_ae;
	assign wr_ad = REG_WR && REG_ADDR == 8'had;
	assign wr_ae = REG_WR && REG_ADDR == 8'hae;
	// shadow of the rail register, built from port traffic only
	always_ff @(posedge CORE_CLK) begin
		if (RESET)
			rail_r <= pgm_pkg::RST_ADJ_RAIL;
		else if (wr_ae)
			rail_r <= REG_WDATA;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	sequence s_trip;
		$rose(EMERGENCY_SHUTDOWN) && !rail_r[5];
	endsequence
	sequence s_off;
		##[2:6] !ADJ_REG_ONE_ON;
	endsequence
	a_read_answer: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
	a_read_rail: assert property (REG_RD && REG_ADDR == 8'hae |=> REG_RDATA == $past(rail_r))
		else $error("rail read data wrong");
	a_term_write: assert property (wr_ad |=> TERMINATION_DISCHARGE_SEL == $past(REG_WDATA[4]))
		else $error("termination discharge not written");
	a_term_hold: assert property (!wr_ad |=> $stable(TERMINATION_DISCHARGE_SEL))
		else $error("termination discharge changed");
	a_disch_write: assert property (wr_ae |=> ADJ_REG_DISCHARGE_SEL == $past(REG_WDATA[7:6]))
		else $error("discharge code not written");
	a_vcode_write: assert property (wr_ae |=> ADJ_REG_VOLTAGE_CODE == $past(REG_WDATA[4:1]))
		else $error("voltage code not written");
	a_rail_disabled: assert property (!rail_r[0] |-> !ADJ_REG_ONE_ON)
		else $error("rail on while disabled");
	a_sdwn_ignored: assert property (rail_r[5] && rail_r[0] |-> ADJ_REG_ONE_ON)
		else $error("rail off while shutdown ignored");
	a_sdwn_trip: assert property (s_trip |-> s_off)
		else $error("rail not forced off by shutdown");
endmodule
`default_nettype wire

//--- sim/tb.sv
/*
 tb: self-checking bench for pgm_regs with the checker bound in.
 Assumes default parameters: 1 ms shutdown hold of 25000 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic CORE_CLK = 0, RESET = 1, REG_WR = 0, REG_RD = 0, CONTROL_INPUT_THREE = 0, CONTROL_INPUT_SIX = 0;
	logic EMERGENCY_SHUTDOWN = 0, REG_RVALID, TERMINATION_DISCHARGE_SEL, ADJ_REG_ONE_ON, LOAD_SWITCH_B_SECOND_ON;
	logic [7:0] REG_ADDR = '0, REG_WDATA = '0, REG_RDATA, m;
	logic [3:0] PG_TREE_IN = '0, PG_OUTPUT, ADJ_REG_VOLTAGE_CODE, pe;
	logic [1:0] ADJ_REG_DISCHARGE_SEL;
	logic [31:0] lfsr = 32'h0000_07ec;
	int fail_count = 0, checks_done = 0;
	always #20 CORE_CLK = ~CORE_CLK;
	pgm_regs uut (.CORE_CLK, .RESET, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID,
		.PG_TREE_IN, .CONTROL_INPUT_THREE, .CONTROL_INPUT_SIX, .EMERGENCY_SHUTDOWN, .PG_OUTPUT,
		.TERMINATION_DISCHARGE_SEL, .ADJ_REG_DISCHARGE_SEL, .ADJ_REG_VOLTAGE_CODE, .ADJ_REG_ONE_ON,
		.LOAD_SWITCH_B_SECOND_ON);
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [3:0] exp_pg(input logic [7:0] k, input logic [3:0] t, input logic a, b);
		logic [3:0] o;
		o[0] = t[0] & (a | k[7]) & (b | k[6]);
		o[3] = t[3] & (a | k[5]) & (b | k[4]);
		o[1] = t[1] & (a | k[3]) & (b | k[2]);
		o[2] = t[2] & (a | k[1]) & (b | k[0]);
		return o;
	endfunction
	task automatic chk(input string n, input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask
	task automatic wr(input logic [7:0] a, d);
		REG_WR = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		cyc(1);
		REG_WR = 1'b0;
		// idle cycle: a following call never re-raises the strobe in the same step
		cyc(1);
	endtask
	task automatic rdchk(input logic [7:0] a, e);
		REG_RD = 1'b1;
		REG_ADDR = a;
		cyc(1);
		REG_RD = 1'b0;
		chk("rvalid", 8'(REG_RVALID), 8'h01);
		chk("rdata", REG_RDATA, e);
		cyc(1);
	endtask
	// watchdog: a hang ends the run as a failure
	initial begin
		repeat (100000) @(posedge CORE_CLK);
		fail_count++;
		final_report();
	end
	initial begin
		cyc(6);
		RESET = 0;
		rdchk(8'hac, pgm_pkg::RST_PG_MASK);
		rdchk(8'had, pgm_pkg::RST_TERM_DISCH);
		rdchk(8'hae, pgm_pkg::RST_ADJ_RAIL);
		rdchk(8'haf, 8'h00);
		wr(8'haf, 8'h5a);
		rdchk(8'hae, pgm_pkg::RST_ADJ_RAIL);
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			lfsr = nxt(lfsr);
			m = pgm_pkg::RST_TERM_DISCH;
			m[4] = lfsr[4];
			wr(8'had, m);
			wr(8'hae, {i[1:0], lfsr[13:8]});
			chk("term", 8'(TERMINATION_DISCHARGE_SEL), 8'(lfsr[4]));
			chk("disch", 8'(ADJ_REG_DISCHARGE_SEL), 8'(i[1:0]));
			chk("vcode", 8'(ADJ_REG_VOLTAGE_CODE), 8'(lfsr[12:9]));
			chk("on", 8'(ADJ_REG_ONE_ON), 8'(lfsr[8]));
			chk("sw2 on", 8'(LOAD_SWITCH_B_SECOND_ON), 8'h00);
			rdchk(8'hae, {i[1:0], lfsr[13:8]});
			rdchk(8'had, m);
		end
		$display("rail test done");
		for (int i = 0; i < 24; i++) begin
			lfsr = nxt(lfsr);
			// first eight: one mask bit, its input low, the other high
			m = i < 8 ? 8'h01 << i : lfsr[7:0];
			wr(8'hac, m);
			{PG_TREE_IN, CONTROL_INPUT_THREE, CONTROL_INPUT_SIX} = i < 8 ? {4'hf, ~i[0], i[0]} : lfsr[21:16];
			cyc(8);
			pe = exp_pg(m, PG_TREE_IN, CONTROL_INPUT_THREE, CONTROL_INPUT_SIX);
			chk("pg", 8'(PG_OUTPUT), 8'(pe));
		end
		$display("mask test done");
		wr(8'hae, 8'h01);
		EMERGENCY_SHUTDOWN = 1;
		cyc(8);
		chk("sdwn off", 8'(ADJ_REG_ONE_ON), 8'h00);
		// hold starts five edges after the pin rises and lasts the full count
		cyc(int'(pgm_pkg::SDWN_CYC_1) - 5);
		chk("sdwn hold", 8'(ADJ_REG_ONE_ON), 8'h00);
		cyc(3);
		chk("sdwn end", 8'(ADJ_REG_ONE_ON), 8'h01);
		EMERGENCY_SHUTDOWN = 0;
		wr(8'hae, 8'h21);
		cyc(4);
		EMERGENCY_SHUTDOWN = 1;
		cyc(10);
		chk("sdwn ign", 8'(ADJ_REG_ONE_ON), 8'h01);
		// edge seen while ignored: clearing bit 5 afterwards starts no hold
		wr(8'hae, 8'h01);
		chk("no hold", 8'(ADJ_REG_ONE_ON), 8'h01);
		wr(8'hae, 8'h20);
		chk("en off", 8'(ADJ_REG_ONE_ON), 8'h00);
		RESET = 1;
		cyc(2);
		RESET = 0;
		rdchk(8'hae, pgm_pkg::RST_ADJ_RAIL);
		$display("shutdown test done");
		final_report();
	end
endmodule
bind pgm_regs pgm_regs_assertions u_chk (.CORE_CLK, .RESET, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
	.REG_RDATA, .REG_RVALID, .EMERGENCY_SHUTDOWN, .TERMINATION_DISCHARGE_SEL, .ADJ_REG_DISCHARGE_SEL,
	.ADJ_REG_VOLTAGE_CODE, .ADJ_REG_ONE_ON);
`default_nettype wire

//--- src/pgm_regs.sv
/*
 pgm_regs: control-input power-good mask, termination discharge and
 adjustable rail control registers, with the rail shutdown hold-off.
 Assumes a byte-wide register port from the host serial bridge on CORE_CLK,
 and that power-good and control-input levels arrive from outside the domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pgm_regs #(
	parameter logic [7:0] MASK_DEFAULT = pgm_pkg::RST_PG_MASK,
	parameter logic [7:0] TERM_DEFAULT = pgm_pkg::RST_TERM_DISCH,
	parameter logic [7:0] RAIL_DEFAULT = pgm_pkg::RST_ADJ_RAIL,
	parameter logic [1:0] SDWN_TIME_SEL = 2'h0,
	parameter logic RAIL_USED = 1'b1,
	parameter logic RAIL_IS_SWITCH = 1'b0
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic [3:0] PG_TREE_IN,
	input wire logic CONTROL_INPUT_THREE,
	input wire logic CONTROL_INPUT_SIX,
	input wire logic EMERGENCY_SHUTDOWN,
	output logic [3:0] PG_OUTPUT,
	output logic TERMINATION_DISCHARGE_SEL,
	output logic [1:0] ADJ_REG_DISCHARGE_SEL,
	output logic [3:0] ADJ_REG_VOLTAGE_CODE,
	output logic ADJ_REG_ONE_ON,
	output logic LOAD_SWITCH_B_SECOND_ON
);
	// factory time code to hold-off cycles; no short test value, so benches wait the full time
	function automatic logic [31:0] hold_for_sel(input logic [1:0] sel);
		logic [31:0] cyc_v;
		cyc_v = pgm_pkg::SDWN_CYC_100;
		case (sel)
			2'h0: begin
				cyc_v = pgm_pkg::SDWN_CYC_1;
			end
			2'h1: begin
				cyc_v = pgm_pkg::SDWN_CYC_5;
			end
			2'h2: begin
				cyc_v = pgm_pkg::SDWN_CYC_10;
			end
			default: begin
				cyc_v = pgm_pkg::SDWN_CYC_100;
			end
		endcase
		return cyc_v;
	endfunction

	localparam logic [31:0] HOLD_CYC = hold_for_sel(SDWN_TIME_SEL);

	pgm_pkg::pgm_req_s req;
	pgm_pkg::pgm_rail_s rail;
	logic [7:0] mask_r;
	logic [7:0] term_r;
	logic [7:0] rail_r;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic [2:0] sync3_r [0:6];
	logic [6:0] clean_r;
	logic [6:0] raw_in;
	logic sdwn_prev_r;
	logic sdwn_start;
	logic sdwn_hold;
	logic rail_on;
	logic [3:0] pg_r;
	logic [3:0] in3_masked;
	logic [3:0] in6_masked;

	assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
	assign raw_in = {EMERGENCY_SHUTDOWN, CONTROL_INPUT_SIX, CONTROL_INPUT_THREE, PG_TREE_IN};

	// three stages; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_sync
			always_ff @(posedge CORE_CLK) begin
				if (RESET) begin
					sync3_r[gi] <= 3'h0;
					clean_r[gi] <= 1'b0;
				end else begin
					sync3_r[gi] <= {sync3_r[gi][1:0], raw_in[gi]};
					if (sync3_r[gi][1] == sync3_r[gi][2]) begin
						clean_r[gi] <= sync3_r[gi][2];
					end
				end
			end
		end
	endgenerate

	// reserved termination bits are stored as written; software keeps them matching
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			mask_r <= MASK_DEFAULT;
			term_r <= TERM_DEFAULT;
			rail_r <= RAIL_DEFAULT;
		end else if (req.wr) begin
			case (req.addr)
				pgm_pkg::OFS_PG_MASK: begin
					mask_r <= req.wdata;
				end
				pgm_pkg::OFS_TERM_DISCH: begin
					term_r <= req.wdata;
				end
				pgm_pkg::OFS_ADJ_RAIL: begin
					rail_r <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		case (req.addr)
			pgm_pkg::OFS_PG_MASK: begin
				rdata_nxt = mask_r;
			end
			pgm_pkg::OFS_TERM_DISCH: begin
				rdata_nxt = term_r;
			end
			pgm_pkg::OFS_ADJ_RAIL: begin
				rdata_nxt = rail_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= req.rd;
		end
	end

	// read data holds until the next read, so a slow host may sample late
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;

	// a set mask bit forces that input to look good, so it drops out of the and-tree
	assign in3_masked[0] = clean_r[4] | mask_r[pgm_pkg::POS_PG1_IN3];
	assign in6_masked[0] = clean_r[5] | mask_r[pgm_pkg::POS_PG1_IN6];
	assign in3_masked[1] = clean_r[4] | mask_r[pgm_pkg::POS_PG2_IN3];
	assign in6_masked[1] = clean_r[5] | mask_r[pgm_pkg::POS_PG2_IN6];
	assign in3_masked[2] = clean_r[4] | mask_r[pgm_pkg::POS_PG3_IN3];
	assign in6_masked[2] = clean_r[5] | mask_r[pgm_pkg::POS_PG3_IN6];
	assign in3_masked[3] = clean_r[4] | mask_r[pgm_pkg::POS_PG4_IN3];
	assign in6_masked[3] = clean_r[5] | mask_r[pgm_pkg::POS_PG4_IN6];

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pg_r <= 4'h0;
		end else begin
			pg_r <= clean_r[3:0] & in3_masked & in6_masked;
		end
	end

	assign PG_OUTPUT = pg_r;

	assign rail.disch_sel = pgm_pkg::pgm_disch_e'(rail_r[pgm_pkg::POS_ADJ_DISCH_HI:pgm_pkg::POS_ADJ_DISCH_LO]);
	assign rail.sdwn_cfg = rail_r[pgm_pkg::POS_SDWN_CFG];
	assign rail.vcode = rail_r[pgm_pkg::POS_VCODE_HI:pgm_pkg::POS_VCODE_LO];
	assign rail.en = rail_r[pgm_pkg::POS_RAIL_EN];

	assign TERMINATION_DISCHARGE_SEL = term_r[pgm_pkg::POS_TERM_DISCH];
	assign ADJ_REG_DISCHARGE_SEL = rail.disch_sel;
	assign ADJ_REG_VOLTAGE_CODE = rail.vcode;

	// rising edge only; a held shutdown level does not retrigger
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			sdwn_prev_r <= 1'b0;
		end else begin
			sdwn_prev_r <= clean_r[6];
		end
	end

	assign sdwn_start = clean_r[6] & ~sdwn_prev_r & ~rail.sdwn_cfg;

	pgm_sdwn_timer #(
		.HOLD_CYC(HOLD_CYC)
	) u_sdwn_timer (
		.clk(CORE_CLK),
		.rst(RESET),
		.start(sdwn_start),
		.active(sdwn_hold)
	);

	// config 1 ignores shutdown; config 0 forces off during the hold-off
	assign rail_on = RAIL_USED & rail.en & (rail.sdwn_cfg | ~sdwn_hold);
	assign ADJ_REG_ONE_ON = rail_on & ~RAIL_IS_SWITCH;
	assign LOAD_SWITCH_B_SECOND_ON = rail_on & RAIL_IS_SWITCH;
endmodule
`default_nettype wire

//--- src/pgm_sdwn_timer.sv
/*
 pgm_sdwn_timer: holds the selected rail off for a fixed time after an
 emergency shutdown request. Assumes the request is already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module pgm_sdwn_timer #(
	parameter logic [31:0] HOLD_CYC = pgm_pkg::SDWN_CYC_1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic active
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 32'h0000_0000;
		end else if (start) begin
			cnt_r <= HOLD_CYC;
		end else if (cnt_r != 32'h0000_0000) begin
			cnt_r <= cnt_r - 32'h0000_0001;
		end
	end

	assign active = (cnt_r != 32'h0000_0000);
endmodule
`default_nettype wire
